//--- common/host_pin_pkg.sv
// Constants shared by the host pin function select logic
package host_pin_pkg;
  // Register offsets
  localparam logic [7:0] CONFIG_REGISTER_16_ADDR = 8'h16;
  localparam logic [7:0] CONFIG_REGISTER_2C_ADDR = 8'h2c;
  localparam logic [7:0] CONFIG_REGISTER_31_ADDR = 8'h31;
  localparam logic [7:0] PM_ADDR = 8'h40;
  localparam logic [7:0] GIO_ADDR = 8'h41;
  localparam logic [7:0] HIR_ADDR = 8'h42;
  localparam logic [7:0] STAT_ADDR = 8'h43;
  // Reset values
  localparam logic [7:0] CONFIG_REGISTER_16_RST = 8'h00;
  localparam logic [7:0] CONFIG_REGISTER_2C_RST = 8'h00;
  localparam logic [7:0] CONFIG_REGISTER_31_RST = 8'h00;
  localparam logic [7:0] PM_RST = 8'h00;
  localparam logic [7:0] GIO_RST = 8'h00;
  localparam logic [7:0] HIR_RST = 8'h00;
  // Field positions
  localparam int PNF_EN_BIT = 7;
  localparam int GPIO_SEL_BIT = 4;
  localparam int IRQ_MODE_BIT = 2;
  localparam int CLK_SEL_BIT = 0;
  localparam int ACPI_MODE_BIT = 0;
  localparam int SMI_EN_BIT = 1;
  localparam int ACPI_LSB = 2;
  localparam int ACPI_MSB = 4;
  localparam int ACPI_LINE_EN_BIT = 5;
  localparam int HIR_DIR_BIT = 0;
  localparam int HIR_SEL0_BIT = 1;
  // Synchronised pin indices
  localparam int S_PNF = 0;
  localparam int S_PIN_A = 1;
  localparam int S_PIN_B = 2;
  localparam int S_ACK_C = 3;
  localparam int S_ACK_D = 4;
  localparam int S_TC = 5;
  localparam int S_IR = 6;
  localparam int S_PCI = 7;
  localparam int SYNC_W = 8;
  // Serial interrupt frame timing, in pci clocks
  localparam logic [3:0] START_CLKS = 4'h4;
  localparam logic [3:0] STOP_CLKS = 4'h2;
  localparam logic [1:0] SLOT_PHASES = 2'h3;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_START = 2'b01,
    SQ_SLOT = 2'b10,
    SQ_STOP = 2'b11
  } serial_interrupt_out_state_t;
endpackage

//--- verilog/pin_sync.sv
// Two flip-flop synchroniser, one per pin bit
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins and synchronised copies
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync_reg
);
  logic [W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          meta_reg[i] <= 1'b0;
          pin_sync_reg[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= pin_in[i];
          pin_sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule

//--- verilog/serial_interrupt_out_frame.sv
// Serial interrupt frame sender stepped by pci clock rising edges
`timescale 1ns/10ps
module serial_interrupt_out_frame #(
  parameter int SLOTS = 15
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic pci_rise,
  input wire logic [SLOTS-1:0] lines,
  // Serial pin
  output logic sirq_out_reg,
  output logic sirq_oe_n_reg
);
  host_pin_pkg::serial_interrupt_out_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [3:0] slot_reg;
  logic [1:0] phase_reg;

  // Frame restarts one pci clock after the stop, so the host sees continuous mode
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= host_pin_pkg::SQ_IDLE;
      cnt_reg <= 4'h0;
      slot_reg <= 4'h0;
      phase_reg <= 2'h0;
      sirq_out_reg <= 1'b1;
      sirq_oe_n_reg <= 1'b1;
    end
    else if (!enable)
    begin
      state_reg <= host_pin_pkg::SQ_IDLE;
      sirq_out_reg <= 1'b1;
      sirq_oe_n_reg <= 1'b1;
    end
    else if (pci_rise)
    begin
      case (state_reg)
        host_pin_pkg::SQ_IDLE:
        begin
          state_reg <= host_pin_pkg::SQ_START;
          cnt_reg <= 4'h0;
          sirq_out_reg <= 1'b0;
          sirq_oe_n_reg <= 1'b0;
        end
        host_pin_pkg::SQ_START:
        begin
          if (cnt_reg == host_pin_pkg::START_CLKS - 4'h1)
          begin
            state_reg <= host_pin_pkg::SQ_SLOT;
            slot_reg <= 4'h0;
            phase_reg <= 2'h0;
            sirq_out_reg <= 1'b0;
            sirq_oe_n_reg <= ~lines[0];
          end
          else
            cnt_reg <= cnt_reg + 4'h1;
        end
        host_pin_pkg::SQ_SLOT:
        begin
          if (phase_reg == 2'h0)
          begin
            // Recovery: drive high only if the sample phase drove low
            phase_reg <= 2'h1;
            sirq_out_reg <= 1'b1;
          end
          else if (phase_reg == host_pin_pkg::SLOT_PHASES - 2'h2)
          begin
            phase_reg <= 2'h2;
            sirq_oe_n_reg <= 1'b1;
          end
          else if (slot_reg == 4'(SLOTS - 1))
          begin
            state_reg <= host_pin_pkg::SQ_STOP;
            cnt_reg <= 4'h0;
            sirq_out_reg <= 1'b0;
            sirq_oe_n_reg <= 1'b0;
          end
          else
          begin
            slot_reg <= slot_reg + 4'h1;
            phase_reg <= 2'h0;
            sirq_out_reg <= 1'b0;
            sirq_oe_n_reg <= ~lines[slot_reg + 4'h1];
          end
        end
        host_pin_pkg::SQ_STOP:
        begin
          if (cnt_reg == host_pin_pkg::STOP_CLKS - 4'h1)
          begin
            state_reg <= host_pin_pkg::SQ_IDLE;
            sirq_out_reg <= 1'b1;
            sirq_oe_n_reg <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg + 4'h1;
        end
        default:
          state_reg <= host_pin_pkg::SQ_IDLE;
      endcase
    end
  end
endmodule

//--- verilog/host_pin_function_select.sv
// Host side pin function selection, interrupt routing and DMA handshake
`timescale 1ns/10ps
module host_pin_function_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Internal function requests
  input wire logic [7:0] irq_src,
  input wire logic pm_event,
  input wire logic dma_need_c,
  input wire logic dma_need_d,
  // DMA pins and data cycle grants
  output logic dma_request_c,
  input wire logic dma_acknowledge_c,
  output logic dma_request_d,
  input wire logic dma_acknowledge_d,
  input wire logic terminal_count,
  output logic dma_cycle_c,
  output logic dma_cycle_d,
  // Interrupt pins; shared pins bit 0 is line A, bit 1 is line B
  output logic [5:0] irq_c_to_h,
  input wire logic [1:0] shared_pin_in,
  output logic [1:0] shared_pin_out,
  output logic [1:0] shared_pin_oe_n,
  output logic serial_interrupt_out,
  output logic serial_interrupt_oe_n,
  input wire logic pci_clock_in,
  output logic acpi_interrupt_out,
  output logic system_mgmt_interrupt_n,
  // Parallel port routing
  input wire logic printer_not_floppy_detect,
  output logic parport_printer_mode,
  // Fast infrared shared pin
  input wire logic infrared_pin_in,
  output logic infrared_module_select_zero,
  output logic infrared_pin_oe_n,
  output logic fast_infrared_receive,
  // Clock input selection
  output logic clock_frequency_select
);
  logic [7:0] config_register_16, config_register_2c, config_register_31;
  logic [7:0] pm_ctrl_reg, gio_ctrl_reg, hir_ctrl_reg;
  logic [1:0] tc_flag_reg, dma_done_reg, dma_req_reg, dma_cyc_reg;
  logic [7:0] line_reg, acpi_hit, irq_eff, rd_next;
  logic [host_pin_pkg::SYNC_W-1:0] sync_q;
  logic pci_d_reg, tc_d_reg, pci_rise, tc_rise;
  logic serial_mode, irq_or_gpio_select;
  logic [1:0] need, ack_s, term;

  pin_sync #(
    .W(host_pin_pkg::SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({pci_clock_in, infrared_pin_in, terminal_count,
             dma_acknowledge_d, dma_acknowledge_c, shared_pin_in[1],
             shared_pin_in[0], printer_not_floppy_detect}),
    .pin_sync_reg(sync_q)
  );
  // Edge detectors look only at the second synchroniser stage
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pci_d_reg <= 1'b0;
      tc_d_reg <= 1'b0;
    end
    else
    begin
      pci_d_reg <= sync_q[host_pin_pkg::S_PCI];
      tc_d_reg <= sync_q[host_pin_pkg::S_TC];
    end
  end
  assign pci_rise = sync_q[host_pin_pkg::S_PCI] & ~pci_d_reg;
  assign tc_rise = sync_q[host_pin_pkg::S_TC] & ~tc_d_reg;
  assign serial_mode = config_register_31[host_pin_pkg::IRQ_MODE_BIT];
  assign irq_or_gpio_select = config_register_16[host_pin_pkg::GPIO_SEL_BIT];
  assign need = {dma_need_d, dma_need_c};
  assign ack_s = {sync_q[host_pin_pkg::S_ACK_D],
                  sync_q[host_pin_pkg::S_ACK_C]};
  assign term = {2{tc_rise}} & ack_s & dma_req_reg;
  // Configuration registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      config_register_16 <= host_pin_pkg::CONFIG_REGISTER_16_RST;
      config_register_2c <= host_pin_pkg::CONFIG_REGISTER_2C_RST;
      config_register_31 <= host_pin_pkg::CONFIG_REGISTER_31_RST;
      pm_ctrl_reg <= host_pin_pkg::PM_RST;
      gio_ctrl_reg <= host_pin_pkg::GIO_RST;
      hir_ctrl_reg <= host_pin_pkg::HIR_RST;
    end
    else if (reg_wr)
      case (reg_addr)
        host_pin_pkg::CONFIG_REGISTER_16_ADDR: config_register_16 <= reg_wdata;
        host_pin_pkg::CONFIG_REGISTER_2C_ADDR: config_register_2c <= reg_wdata;
        host_pin_pkg::CONFIG_REGISTER_31_ADDR: config_register_31 <= reg_wdata;
        host_pin_pkg::PM_ADDR: pm_ctrl_reg <= reg_wdata;
        host_pin_pkg::GIO_ADDR: gio_ctrl_reg <= reg_wdata;
        host_pin_pkg::HIR_ADDR: hir_ctrl_reg <= reg_wdata;
        default: ;
      endcase
  end
  // Read data, one cycle after the strobe; unmapped reads return zero
  always_comb
  begin
    rd_next = 8'h00;
    case (reg_addr)
      host_pin_pkg::CONFIG_REGISTER_16_ADDR: rd_next = config_register_16;
      host_pin_pkg::CONFIG_REGISTER_2C_ADDR: rd_next = config_register_2c;
      host_pin_pkg::CONFIG_REGISTER_31_ADDR: rd_next = config_register_31;
      host_pin_pkg::PM_ADDR: rd_next = pm_ctrl_reg;
      host_pin_pkg::GIO_ADDR: rd_next = gio_ctrl_reg;
      host_pin_pkg::HIR_ADDR: rd_next = hir_ctrl_reg;
      host_pin_pkg::STAT_ADDR:
        rd_next = {1'b0, pm_event, sync_q[host_pin_pkg::S_IR], tc_flag_reg,
                   sync_q[host_pin_pkg::S_PIN_B],
                   sync_q[host_pin_pkg::S_PIN_A], parport_printer_mode};
      default: rd_next = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
    else
      reg_rdata <= 8'h00;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      parport_printer_mode <= 1'b1;
    else if (config_register_16[host_pin_pkg::PNF_EN_BIT])
      parport_printer_mode <= sync_q[host_pin_pkg::S_PNF];
    else
      parport_printer_mode <= 1'b1;
  end
  // Clock select passed to the clock divider as software set it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      clock_frequency_select <= 1'b0;
    else
      clock_frequency_select <= config_register_2c[host_pin_pkg::CLK_SEL_BIT];
  end
  // ACPI event folded onto the chosen interrupt line
  always_comb
  begin
    acpi_hit = 8'h00;
    if (pm_ctrl_reg[host_pin_pkg::ACPI_MODE_BIT] &&
        pm_ctrl_reg[host_pin_pkg::ACPI_LINE_EN_BIT] && pm_event)
      acpi_hit[pm_ctrl_reg[host_pin_pkg::ACPI_MSB:host_pin_pkg::ACPI_LSB]] =
        1'b1;
    irq_eff = irq_src | acpi_hit;
  end
  // Power events pull the management interrupt low
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      system_mgmt_interrupt_n <= 1'b1;
      acpi_interrupt_out <= 1'b0;
    end
    else
    begin
      system_mgmt_interrupt_n <=
        ~(pm_event & pm_ctrl_reg[host_pin_pkg::SMI_EN_BIT]);
      acpi_interrupt_out <=
        pm_event & pm_ctrl_reg[host_pin_pkg::ACPI_MODE_BIT];
    end
  end
  // Parallel lines held low while the serial pin carries interrupts
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      line_reg <= 8'h00;
    else if (serial_mode)
      line_reg <= 8'h00;
    else
      line_reg <= irq_eff;
  end
  assign irq_c_to_h = line_reg[7:2];
  // Pin A pairs with I/O line one, pin B with I/O line zero
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_shared
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          shared_pin_out[p] <= 1'b0;
          shared_pin_oe_n[p] <= 1'b0;
        end
        else if (irq_or_gpio_select)
        begin
          shared_pin_out[p] <= gio_ctrl_reg[1 - p];
          shared_pin_oe_n[p] <= ~gio_ctrl_reg[3 - p];
        end
        else
        begin
          shared_pin_out[p] <= irq_eff[p] & ~serial_mode;
          shared_pin_oe_n[p] <= 1'b0;
        end
      end
    end
  endgenerate
  // Serial frame paced by pci clock edges; pci clock must be
  // well below half of mclk or edges are lost in the synchroniser
  serial_interrupt_out_frame #(
    .SLOTS(15)
  ) u_serial_interrupt_out (
    .mclk(mclk),
    .rst(rst),
    .enable(serial_mode),
    .pci_rise(pci_rise),
    .lines({7'h00, irq_eff}),
    .sirq_out_reg(serial_interrupt_out),
    .sirq_oe_n_reg(serial_interrupt_oe_n)
  );
  // Fast infrared pin direction from its control register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      infrared_pin_oe_n <= 1'b1;
      infrared_module_select_zero <= 1'b0;
      fast_infrared_receive <= 1'b0;
    end
    else
    begin
      infrared_pin_oe_n <= ~hir_ctrl_reg[host_pin_pkg::HIR_DIR_BIT];
      infrared_module_select_zero <= hir_ctrl_reg[host_pin_pkg::HIR_SEL0_BIT];
      fast_infrared_receive <= sync_q[host_pin_pkg::S_IR] &
                               ~hir_ctrl_reg[host_pin_pkg::HIR_DIR_BIT];
    end
  end
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_dma
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          dma_done_reg[c] <= 1'b0;
          dma_req_reg[c] <= 1'b0;
          dma_cyc_reg[c] <= 1'b0;
        end
        else
        begin
          // Terminal count ends the transfer until need drops
          if (!need[c])
            dma_done_reg[c] <= 1'b0;
          else if (term[c])
            dma_done_reg[c] <= 1'b1;
          // Request on need, data cycle only under acknowledge
          dma_req_reg[c] <= need[c] & ~dma_done_reg[c] & ~term[c];
          dma_cyc_reg[c] <= dma_req_reg[c] & ack_s[c] & ~term[c];
        end
      end

      // Termination seen; a new event beats a clear in the same cycle
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          tc_flag_reg[c] <= 1'b0;
        else if (term[c])
          tc_flag_reg[c] <= 1'b1;
        else if (reg_wr && reg_addr == host_pin_pkg::STAT_ADDR &&
                 reg_wdata[3 + c])
          tc_flag_reg[c] <= 1'b0;
      end
    end
  endgenerate

  assign dma_request_c = dma_req_reg[0];
  assign dma_request_d = dma_req_reg[1];
  assign dma_cycle_c = dma_cyc_reg[0];
  assign dma_cycle_d = dma_cyc_reg[1];

  printer_on_a: assert property (@(posedge mclk) disable iff (rst)
    config_register_16[7] && sync_q[0] |=> parport_printer_mode)
    else $error("printer mode not taken on detect high");
  floppy_on_a: assert property (@(posedge mclk) disable iff (rst)
    config_register_16[7] && !sync_q[0] |=> !parport_printer_mode)
    else $error("floppy mode not taken on detect low");
  detect_off_a: assert property (@(posedge mclk) disable iff (rst)
    !config_register_16[7] |=> parport_printer_mode)
    else $error("detect used while disabled");
  irq_pin_a: assert property (@(posedge mclk) disable iff (rst)
    !config_register_16[4] |=> !shared_pin_oe_n[0] &&
    shared_pin_out[0] == line_reg[0])
    else $error("pin A does not carry request A");
  gio_one_a: assert property (@(posedge mclk) disable iff (rst)
    config_register_16[4] |=> shared_pin_oe_n[0] == !$past(gio_ctrl_reg[3])
    && shared_pin_out[0] == $past(gio_ctrl_reg[1]))
    else $error("pin A not acting as I/O line one");
  gio_zero_a: assert property (@(posedge mclk) disable iff (rst)
    config_register_16[4] |=> shared_pin_oe_n[1] == !$past(gio_ctrl_reg[2]))
    else $error("pin B not acting as I/O line zero");
  serial_only_a: assert property (@(posedge mclk) disable iff (rst)
    serial_mode |=> irq_c_to_h == 6'h00)
    else $error("parallel lines driven in serial mode");
  serial_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !serial_mode |=> serial_interrupt_oe_n)
    else $error("serial pin driven while not selected");
  pci_paced_a: assert property (@(posedge mclk) disable iff (rst)
    serial_mode && $past(serial_mode) && $changed(serial_interrupt_oe_n)
    |-> $past(pci_rise))
    else $error("serial pin moved without a pci edge");
  tc_stop_a: assert property (@(posedge mclk) disable iff (rst)
    term[0] |=> !dma_request_c [*2])
    else $error("request kept after terminal count");
  ir_dir_a: assert property (@(posedge mclk) disable iff (rst)
    hir_ctrl_reg[0] |=> !infrared_pin_oe_n && !fast_infrared_receive)
    else $error("infrared pin direction wrong");
  smi_low_a: assert property (@(posedge mclk) disable iff (rst)
    pm_event && pm_ctrl_reg[1] |=> !system_mgmt_interrupt_n)
    else $error("management interrupt not asserted");
  acpi_map_a: assert property (@(posedge mclk) disable iff (rst)
    !serial_mode && pm_ctrl_reg[0] && pm_ctrl_reg[5] && pm_event
    |=> line_reg[$past(pm_ctrl_reg[4:2])])
    else $error("acpi event missing on chosen line");
  gio_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    config_register_16[4] && !gio_ctrl_reg[1] && irq_eff[0]
    |=> !shared_pin_out[0])
    else $error("request leaked onto I/O pin");
  ack_gate_a: assert property (@(posedge mclk) disable iff (rst)
    dma_cycle_c |-> $past(ack_s[0]) && $past(dma_req_reg[0]))
    else $error("data cycle without acknowledge");

  frame_c: cover property (@(posedge mclk) disable iff (rst)
    serial_mode && $fell(serial_interrupt_oe_n));
  tc_end_c: cover property (@(posedge mclk) disable iff (rst) term[1]);
  floppy_c: cover property (@(posedge mclk) disable iff (rst)
    $fell(parport_printer_mode));
endmodule

//--- sim/host_model.sv
// Host chipset model: DMA acknowledge, terminal count and pci clock
`timescale 1ns/10ps
module host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // High selects a slow acknowledge
  input wire logic slow,
  // DMA pins
  input wire logic dma_request_c,
  input wire logic dma_request_d,
  output logic dma_acknowledge_c,
  output logic dma_acknowledge_d,
  output logic terminal_count,
  // Pci clock runs free, as on a real host bus
  output logic pci_clock_in
);
  logic [3:0] busy_reg;
  logic [2:0] div_reg;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      busy_reg <= 4'h0;
    else if (!(dma_request_c || dma_request_d))
      busy_reg <= 4'h0;
    else if (busy_reg != 4'hf)
      busy_reg <= busy_reg + 4'h1;
  end
  assign dma_acknowledge_c = dma_request_c && busy_reg >= (slow ? 6 : 1);
  assign dma_acknowledge_d = dma_request_d && busy_reg >= (slow ? 6 : 1);
  // end the transfer once it has run
  assign terminal_count = busy_reg == 4'hc || busy_reg == 4'hd;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      div_reg <= 3'h0;
    else
      div_reg <= div_reg + 3'h1;
  end
  // pci clock from the host side
  assign pci_clock_in = div_reg[2];
endmodule

//--- sim/testbench.sv
// Self-checking bench for the host pin function select block
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pm_event = 1'b0;
  logic dma_need_c = 1'b0;
  logic dma_need_d = 1'b0;
  logic printer_not_floppy_detect = 1'b1;
  logic slow = 1'b0;
  logic ir_ext = 1'b0;
  logic [1:0] ext_pin = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] irq_src = 8'h00;
  logic [7:0] reg_rdata, rv;
  logic [5:0] irq_c_to_h;
  logic [1:0] shared_pin_in, shared_pin_out, shared_pin_oe_n;
  logic dma_request_c, dma_request_d, dma_acknowledge_c, dma_acknowledge_d;
  logic terminal_count, dma_cycle_c, dma_cycle_d, pci_clock_in;
  logic serial_interrupt_out, serial_interrupt_oe_n, acpi_interrupt_out;
  logic system_mgmt_interrupt_n, parport_printer_mode, infrared_pin_in;
  logic infrared_module_select_zero, infrared_pin_oe_n;
  logic fast_infrared_receive, clock_frequency_select;
  int n_errors = 0;
  int cmp_count = 0;
  int ticks = 0;

  always #10 mclk = ~mclk;
  // Wire level resolved from the DUT enable alone; the external side drives whenever it is off
  assign shared_pin_in = (~shared_pin_oe_n & shared_pin_out) |
    (shared_pin_oe_n & ext_pin);
  assign infrared_pin_in = infrared_pin_oe_n ? ir_ext :
    infrared_module_select_zero;

  host_pin_function_select dut (.mclk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq_src, .pm_event, .dma_need_c,
    .dma_need_d, .dma_request_c, .dma_acknowledge_c, .dma_request_d,
    .dma_acknowledge_d, .terminal_count, .dma_cycle_c, .dma_cycle_d,
    .irq_c_to_h, .shared_pin_in, .shared_pin_out, .shared_pin_oe_n,
    .serial_interrupt_out, .serial_interrupt_oe_n, .pci_clock_in,
    .acpi_interrupt_out, .system_mgmt_interrupt_n,
    .printer_not_floppy_detect, .parport_printer_mode, .infrared_pin_in,
    .infrared_module_select_zero, .infrared_pin_oe_n,
    .fast_infrared_receive, .clock_frequency_select);
  host_model model (.mclk, .rst, .slow, .dma_request_c, .dma_request_d,
    .dma_acknowledge_c, .dma_acknowledge_d, .terminal_count, .pci_clock_in);

  task automatic chk(input string nm, input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_detect();
    chk("printer", parport_printer_mode, 1);
    wr(8'h16, 8'h80);
    @(posedge mclk) printer_not_floppy_detect <= 1'b0;
    cyc(6);
    chk("floppy", parport_printer_mode, 0);
    @(posedge mclk) printer_not_floppy_detect <= 1'b1;
    cyc(6);
    chk("printer", parport_printer_mode, 1);
    @(posedge mclk) printer_not_floppy_detect <= 1'b0;
    wr(8'h16, 8'h00);
    cyc(6);
    chk("detect off", parport_printer_mode, 1);
    rd(8'h5a);
    chk("unmapped", rv, 8'h00);
  endtask
  task automatic t_shared();
    @(posedge mclk) irq_src <= 8'hff;
    cyc(3);
    chk("irq ab", shared_pin_out, 2'b11);
    chk("irq oe", shared_pin_oe_n, 2'b00);
    chk("irq c_h", irq_c_to_h, 6'h3f);
    wr(8'h41, 8'h0a);
    wr(8'h16, 8'h10);
    @(posedge mclk) ext_pin <= 2'b11;
    cyc(4);
    chk("gio oe", shared_pin_oe_n, 2'b10);
    chk("gio a", shared_pin_out[0], 1);
    chk("no irq b", shared_pin_out[1], 0);
    rd(8'h43);
    chk("gio in", rv[2:1], 2'b11);
    @(posedge mclk) ext_pin <= 2'b00;
    wr(8'h41, 8'h05);
    cyc(4);
    chk("gio oe", shared_pin_oe_n, 2'b01);
    chk("gio b", shared_pin_out[1], 1);
    rd(8'h43);
    chk("gio in", rv[2:1], 2'b10);
    wr(8'h16, 8'h00);
  endtask
  task automatic t_serial();
    wr(8'h31, 8'h04);
    for (int i = 0; i < 300 && serial_interrupt_oe_n !== 1'b0; i++) cyc(1);
    chk("ser oe", serial_interrupt_oe_n, 0);
    chk("ser start", serial_interrupt_out, 0);
    chk("par off", irq_c_to_h, 6'h00);
    cyc(36);
    chk("ser hold", serial_interrupt_out, 0);
    cyc(8);
    chk("ser rec", {serial_interrupt_out, serial_interrupt_oe_n}, 2'h2);
    wr(8'h31, 8'h00);
    cyc(3);
    chk("ser off", serial_interrupt_oe_n, 1);
  endtask
  task automatic t_pm();
    @(posedge mclk) irq_src <= 8'h00;
    wr(8'h2c, 8'h01);
    cyc(2);
    chk("clksel", clock_frequency_select, 1);
    wr(8'h40, 8'h2f);
    @(posedge mclk) pm_event <= 1'b1;
    cyc(3);
    chk("smi", system_mgmt_interrupt_n, 0);
    chk("acpi", acpi_interrupt_out, 1);
    chk("acpi line", irq_c_to_h, 6'h02);
    @(posedge mclk) pm_event <= 1'b0;
    cyc(3);
    chk("smi idle", system_mgmt_interrupt_n, 1);
  endtask
  task automatic t_dma(input logic s);
    @(posedge mclk) slow <= s;
    dma_need_c <= 1'b1;
    dma_need_d <= 1'b1;
    for (int i = 0; i < 5 && dma_request_c !== 1'b1; i++) cyc(1);
    chk("req", {dma_request_c, dma_request_d}, 2'b11);
    chk("early cyc", dma_cycle_c, 0);
    for (int i = 0; i < 30 && dma_cycle_c !== 1'b1; i++) cyc(1);
    chk("cycle", {dma_cycle_c, dma_cycle_d}, 2'b11);
    for (int i = 0; i < 40 && dma_request_c !== 1'b0; i++) cyc(1);
    cyc(6);
    chk("ended", {dma_request_c, dma_cycle_c, dma_cycle_d}, 0);
    rd(8'h43);
    chk("tc flags", rv & 8'h18, 8'h18);
    wr(8'h43, 8'h18);
    rd(8'h43);
    chk("tc clear", rv & 8'h18, 8'h00);
    @(posedge mclk) dma_need_c <= 1'b0;
    dma_need_d <= 1'b0;
  endtask
  task automatic t_ir();
    @(posedge mclk) ir_ext <= 1'b1;
    cyc(4);
    chk("ir in", {infrared_pin_oe_n, fast_infrared_receive}, 2'b11);
    wr(8'h42, 8'h03);
    cyc(3);
    chk("ir out", infrared_pin_oe_n, 0);
    chk("ir sel", infrared_module_select_zero, 1);
    chk("ir rx off", fast_infrared_receive, 0);
  endtask

  always @(posedge mclk)
  begin
    ticks++;
    if (ticks == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_detect();
    t_shared();
    t_serial();
    t_pm();
    t_dma(1'b0);
    t_dma(1'b1);
    t_ir();
    report_and_stop();
  end
endmodule
